// *** pkg/ctx_defines.vh ***
// constants for the can transmit buffer process block
`ifndef CTX_DEFINES_VH
`define CTX_DEFINES_VH

// ************************************************************
// buffer geometry
// ************************************************************
`define CTX_NUM_BUF      16
`define CTX_BUF_IDX_W    4
`define CTX_ID_W         16
`define CTX_BYTE_W       8
`define CTX_MAX_BYTES    8
`define CTX_LEN_W        4
`define CTX_BYTE_IDX_W   3
`define CTX_MAX_LEN      4'h8
`define CTX_HDR_BYTES    4'h5
`define CTX_SYNC_CNT     4'ha

// ************************************************************
// code field values
// ************************************************************
`define CTX_CODE_W       4
`define CTX_CODE_TX_OFF  4'h8
`define CTX_CODE_TX_ON   4'hc
`define CTX_CODE_RESET   4'h0

// ************************************************************
// host write selectors
// ************************************************************
`define CTX_SEL_W        2
`define CTX_SEL_CTRL     2'h0
`define CTX_SEL_IDHI     2'h1
`define CTX_SEL_IDLO     2'h2
`define CTX_SEL_DATA     2'h3

// ************************************************************
// output fifo
// ************************************************************
`define CTX_FIFO_W       8
`define CTX_FIFO_DEPTH   16
`define CTX_FIFO_AW      4
`define CTX_FIFO_CNT_W   5

`endif

// *** logic/ctx_fifo.v ***
// parameterised valid/ready fifo for the serial byte stream
`default_nettype none
`include "ctx_defines.vh"

module ctx_fifo #(
    parameter WIDTH = `CTX_FIFO_W,
    parameter DEPTH = `CTX_FIFO_DEPTH,
    parameter AW    = `CTX_FIFO_AW
) (
    // clock, reset, enable
    input  wire             sys_clk,
    input  wire             rst_b,
    input  wire             clk_en,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    wire            push;
    wire            pop;

    // honest flags straight from the count
    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready & clk_en;
    assign pop       = out_valid & out_ready & clk_en;

    // storage has no reset, saves area
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers and count
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // data output registered: head word is shown while valid
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            out_data <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            if (push && (count_r == {(AW+1){1'b0}} || (pop && count_r == 1))) begin
                out_data <= in_data;
            end else if (pop) begin
                out_data <= mem[rd_ptr_r + 1'b1];
            end
        end
    end

endmodule // ctx_fifo
`default_nettype wire

// *** logic/ctx_tx_core.v ***
// transmit message buffers, internal arbitration and serial feed
`default_nettype none
`include "ctx_defines.vh"

module ctx_tx_core (
    // clock, reset, enable
    input  wire                        sys_clk,
    input  wire                        rst_b,
    input  wire                        clk_en,
    // host buffer write port
    input  wire                        host_wr,
    input  wire [`CTX_BUF_IDX_W-1:0]   host_buf,
    input  wire [`CTX_SEL_W-1:0]       host_sel,
    input  wire [`CTX_BYTE_IDX_W-1:0]  host_byte,
    input  wire [`CTX_ID_W-1:0]        host_wdata,
    // mode control
    input  wire                        freeze_req,
    // receiver bus state
    input  wire                        bus_idle,
    input  wire                        interframe,
    // serial stream toward the shifter
    output wire                        ser_valid,
    input  wire                        ser_ready,
    output wire [`CTX_FIFO_W-1:0]      ser_data,
    // status
    output reg                         synced,
    output reg                         tx_busy,
    output reg  [`CTX_BUF_IDX_W-1:0]   tx_buf,
    output reg                         tx_done
);

    // ************************************************************
    // state
    // ************************************************************
    localparam ST_FREEZE = 3'h0;
    localparam ST_SYNC   = 3'h1;
    localparam ST_IDLE   = 3'h2;
    localparam ST_LOAD   = 3'h3;
    localparam ST_SEND   = 3'h4;

    localparam [`CTX_BYTE_IDX_W:0] SYNC_CNT  = `CTX_SYNC_CNT;  // idle samples to be synced
    localparam [`CTX_BYTE_IDX_W:0] HDR_BYTES = `CTX_HDR_BYTES; // id hi, id lo, length

    reg [`CTX_CODE_W-1:0]   code_r  [0:`CTX_NUM_BUF-1];
    reg [`CTX_LEN_W-1:0]    len_r   [0:`CTX_NUM_BUF-1];
    reg [`CTX_ID_W-1:0]     idhi_r  [0:`CTX_NUM_BUF-1];
    reg [`CTX_ID_W-1:0]     idlo_r  [0:`CTX_NUM_BUF-1];
    reg [`CTX_BYTE_W-1:0]   data_r  [0:`CTX_NUM_BUF*`CTX_MAX_BYTES-1];

    // serial message buffer: snapshot of the winning frame
    reg [`CTX_ID_W-1:0]     smb_idhi_r;
    reg [`CTX_ID_W-1:0]     smb_idlo_r;
    reg [`CTX_LEN_W-1:0]    smb_len_r;
    reg [`CTX_BYTE_W-1:0]   smb_data_r [0:`CTX_MAX_BYTES-1];

    reg [2:0]               state_r;
    reg [`CTX_BYTE_IDX_W:0] cnt_r;
    reg [`CTX_BYTE_IDX_W:0] pos_r;

    wire [`CTX_NUM_BUF-1:0] active;
    reg                     win_any;
    reg [`CTX_BUF_IDX_W-1:0] win_idx;
    reg [`CTX_FIFO_W-1:0]   byte_nxt;
    reg [`CTX_BYTE_IDX_W:0] total_nxt;
    wire                    fifo_ready;
    wire                    push;
    integer                 i;

    // clip length to payload limit
    function [`CTX_LEN_W-1:0] clip_len;
        input [`CTX_LEN_W-1:0] l;
        begin
            clip_len = (l > `CTX_MAX_LEN) ? `CTX_MAX_LEN : l;
        end
    endfunction

    // ************************************************************
    // arbitration
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < `CTX_NUM_BUF; g = g + 1) begin : g_act
            assign active[g] = (code_r[g] == `CTX_CODE_TX_ON);
        end
    endgenerate

    // single winner
    // lowest index wins; fixed priority keeps the choice deterministic
    always @* begin
        win_any = 1'b0;
        win_idx = {`CTX_BUF_IDX_W{1'b0}};
        for (i = `CTX_NUM_BUF - 1; i >= 0; i = i - 1) begin
            if (active[i]) begin
                win_any = 1'b1;
                win_idx = i[`CTX_BUF_IDX_W-1:0];
            end
        end
    end

    // ************************************************************
    // serial byte sequence: idhi, idlo, length, payload
    // ************************************************************
    // eight byte cap
    always @* begin
        total_nxt = HDR_BYTES + smb_len_r - 4'h2;
        case (pos_r)
            4'h0:    byte_nxt = smb_idhi_r[15:8];
            4'h1:    byte_nxt = smb_idhi_r[7:0];
            4'h2:    byte_nxt = smb_idlo_r[15:8];
            4'h3:    byte_nxt = smb_idlo_r[7:0];
            4'h4:    byte_nxt = {4'h0, smb_len_r};
            default: byte_nxt = smb_data_r[pos_r[`CTX_BYTE_IDX_W-1:0] - 3'h5];
        endcase
    end

    assign push = (state_r == ST_SEND) & fifo_ready;

    // ************************************************************
    // host writes, snapshot and sequencing
    // ************************************************************
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= ST_FREEZE;
            cnt_r      <= {(`CTX_BYTE_IDX_W+1){1'b0}};
            pos_r      <= {(`CTX_BYTE_IDX_W+1){1'b0}};
            synced     <= 1'b0;
            tx_busy    <= 1'b0;
            tx_buf     <= {`CTX_BUF_IDX_W{1'b0}};
            tx_done    <= 1'b0;
            smb_idhi_r <= {`CTX_ID_W{1'b0}};
            smb_idlo_r <= {`CTX_ID_W{1'b0}};
            smb_len_r  <= {`CTX_LEN_W{1'b0}};
            for (i = 0; i < `CTX_NUM_BUF; i = i + 1) begin
                code_r[i] <= `CTX_CODE_RESET;
                len_r[i]  <= {`CTX_LEN_W{1'b0}};
                idhi_r[i] <= {`CTX_ID_W{1'b0}};
                idlo_r[i] <= {`CTX_ID_W{1'b0}};
            end
            for (i = 0; i < `CTX_NUM_BUF*`CTX_MAX_BYTES; i = i + 1) begin
                data_r[i] <= {`CTX_BYTE_W{1'b0}};
            end
            for (i = 0; i < `CTX_MAX_BYTES; i = i + 1) begin
                smb_data_r[i] <= {`CTX_BYTE_W{1'b0}};
            end
        end else if (clk_en) begin
            tx_done <= 1'b0;
            // host edits stored as given, but a code written to tx_buf in ST_LOAD is overridden by CTX_CODE_TX_OFF
            // deactivation written before the buffer's ST_LOAD cycle drops it out of arbitration; one written in ST_LOAD still loads the frame; id and data edits leave it in
            if (host_wr) begin
                case (host_sel)
                    `CTX_SEL_CTRL: begin
                        code_r[host_buf] <= host_wdata[`CTX_CODE_W+`CTX_LEN_W-1:`CTX_LEN_W];
                        len_r[host_buf]  <= host_wdata[`CTX_LEN_W-1:0];
                    end
                    `CTX_SEL_IDHI: idhi_r[host_buf] <= host_wdata;
                    `CTX_SEL_IDLO: idlo_r[host_buf] <= host_wdata;
                    default: data_r[{host_buf, host_byte}] <= host_wdata[`CTX_BYTE_W-1:0];
                endcase
            end
            case (state_r)
                ST_FREEZE: begin
                    synced <= 1'b0;
                    if (!freeze_req) begin
                        state_r <= ST_SYNC;
                        cnt_r   <= {(`CTX_BYTE_IDX_W+1){1'b0}};
                    end
                end
                ST_SYNC: begin
                    if (freeze_req) begin
                        state_r <= ST_FREEZE;
                    end else if (!bus_idle) begin
                        cnt_r <= {(`CTX_BYTE_IDX_W+1){1'b0}};
                    end else if (cnt_r == SYNC_CNT - 4'h1) begin
                        state_r <= ST_IDLE;
                        synced  <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                ST_IDLE: begin
                    // nothing starts without an active buffer
                    if (freeze_req) begin
                        state_r <= ST_FREEZE;
                    end else if (win_any && (bus_idle || interframe)) begin
                        state_r <= ST_LOAD;
                        tx_buf  <= win_idx;
                    end
                end
                ST_LOAD: begin
                    // copy winner to serial buffer
                    // recheck the code: host may have deactivated it meanwhile
                    if (code_r[tx_buf] == `CTX_CODE_TX_ON) begin
                        smb_idhi_r <= idhi_r[tx_buf];
                        smb_idlo_r <= idlo_r[tx_buf];
                        smb_len_r  <= clip_len(len_r[tx_buf]);
                        for (i = 0; i < `CTX_MAX_BYTES; i = i + 1) begin
                            smb_data_r[i] <= data_r[{tx_buf, i[`CTX_BYTE_IDX_W-1:0]}];
                        end
                        code_r[tx_buf] <= `CTX_CODE_TX_OFF;
                        pos_r   <= {(`CTX_BYTE_IDX_W+1){1'b0}};
                        tx_busy <= 1'b1;
                        state_r <= ST_SEND;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_SEND: begin
                    // fifo back-pressure stalls the sequencing
                    if (push) begin
                        if (pos_r == total_nxt + 4'h1) begin
                            tx_busy <= 1'b0;
                            tx_done <= 1'b1;
                            state_r <= ST_IDLE;
                        end else begin
                            pos_r <= pos_r + 4'h1;
                        end
                    end
                end
                default: state_r <= ST_FREEZE;
            endcase
        end
    end

    // ************************************************************
    // fifo between serial buffer and shifter
    // ************************************************************
    ctx_fifo #(
        .WIDTH (`CTX_FIFO_W),
        .DEPTH (`CTX_FIFO_DEPTH),
        .AW    (`CTX_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_valid  (state_r == ST_SEND),
        .in_ready  (fifo_ready),
        .in_data   (byte_nxt),
        .out_valid (ser_valid),
        .out_ready (ser_ready),
        .out_data  (ser_data)
    );

endmodule // ctx_tx_core
`default_nettype wire

// *** testbench/ctx_tx_chk_sva.sv ***
// port-level checks on the transmit buffer core
`default_nettype none
`include "ctx_defines.vh"
module ctx_tx_chk (
    // clock and reset
    input wire logic                      sys_clk,
    input wire logic                      rst_b,
    // controls and bus state
    input wire logic                      freeze_req,
    input wire logic                      bus_idle,
    input wire logic                      interframe,
    // serial stream
    input wire logic                      ser_valid,
    input wire logic                      ser_ready,
    input wire logic [`CTX_FIFO_W-1:0]    ser_data,
    // status
    input wire logic                      synced,
    input wire logic                      tx_busy,
    input wire logic [`CTX_BUF_IDX_W-1:0] tx_buf,
    input wire logic                      tx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // sequences and properties
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_feed_start; $rose(tx_busy); endsequence
    sequence s_feed_end; tx_done && !tx_busy; endsequence
    chk_bus_free: assert property (
        s_feed_start |-> $past(bus_idle | interframe) | $past(bus_idle | interframe, 2)
        | $past(bus_idle | interframe, 3) | $past(bus_idle | interframe, 4))
        else $error("feed started without a free bus");
    chk_quiet_bus: assert property (
        (!bus_idle && !interframe) [*5] |-> !$rose(tx_busy))
        else $error("feed started on a busy bus");
    chk_feed_ends: assert property (
        s_feed_start |-> ##[4:1000] s_feed_end) else $error("feed never finished");
    chk_done_ends: assert property (
        $fell(tx_busy) |-> tx_done) else $error("feed ended without done");
    chk_done_pulse: assert property (
        tx_done |=> !tx_done) else $error("done longer than one cycle");
    chk_hold_byte: assert property (
        ser_valid && !ser_ready |=> ser_valid && $stable(ser_data))
        else $error("stalled byte changed");
    chk_buf_hold: assert property (
        tx_busy && $past(tx_busy) |-> $stable(tx_buf)) else $error("source changed in feed");
    chk_frozen_quiet: assert property (
        freeze_req [*2] |=> !synced && !tx_busy) else $error("active while frozen");
    chk_sync_wait: assert property (
        $fell(freeze_req) |-> !synced [*8]) else $error("synced too early");
    chk_busy_synced: assert property (
        tx_busy |-> synced) else $error("feed before sync");
endmodule // ctx_tx_chk

bind ctx_tx_core ctx_tx_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .freeze_req(freeze_req),
    .bus_idle(bus_idle), .interframe(interframe), .ser_valid(ser_valid),
    .ser_ready(ser_ready), .ser_data(ser_data), .synced(synced), .tx_busy(tx_busy),
    .tx_buf(tx_buf), .tx_done(tx_done));
`default_nettype wire

// *** testbench/ctx_shift_model.sv ***
// behavioural serial shifter draining the byte stream
`default_nettype none
module ctx_shift_model (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    // stall control from the bench
    input  wire logic       stall_en,
    // stream from the core
    input  wire logic       ser_valid,
    input  wire logic [7:0] ser_data,
    output var  logic       ser_ready,
    // one pulse per byte taken
    output var  logic       got,
    output var  logic [7:0] got_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    // stalls let the fifo fill; ready changes off the sampling edge
    always @(negedge sys_clk or negedge rst_b) begin
        if (!rst_b) ser_ready <= 1'b0;
        else ser_ready <= !stall_en || ($urandom % 4 == 0);
    end
    // a byte is taken where valid and ready meet at the edge
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            got      <= 1'b0;
            got_byte <= 8'h00;
        end else begin
            got      <= ser_valid && ser_ready;
            got_byte <= ser_data;
        end
    end
endmodule // ctx_shift_model
`default_nettype wire

// *** testbench/ctx_tx_core_bench.sv ***
// self-checking bench for the transmit buffer core
`default_nettype none
`include "ctx_defines.vh"
module ctx_tx_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rst_b, host_wr, freeze_req, bus_idle, interframe, stall_en;
    logic [3:0]  host_buf;
    logic [1:0]  host_sel;
    logic [2:0]  host_byte;
    logic [15:0] host_wdata;
    wire         ser_valid, ser_ready, synced, tx_busy, tx_done, got;
    wire  [7:0]  ser_data, got_byte;
    wire  [3:0]  tx_buf;
    logic [8:0]  exp_q[$];
    logic [8:0]  fr[16][$];
    logic [3:0]  buf_q[$];
    int          num_errors = 0, checks = 0, busy_seen = 0, mark;
    int          lens[4] = '{0, 8, 9, 15};

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    ctx_tx_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .host_wr(host_wr),
        .host_buf(host_buf), .host_sel(host_sel), .host_byte(host_byte),
        .host_wdata(host_wdata), .freeze_req(freeze_req), .bus_idle(bus_idle),
        .interframe(interframe), .ser_valid(ser_valid), .ser_ready(ser_ready),
        .ser_data(ser_data), .synced(synced), .tx_busy(tx_busy), .tx_buf(tx_buf),
        .tx_done(tx_done));
    ctx_shift_model u_far (.sys_clk(sys_clk), .rst_b(rst_b), .stall_en(stall_en),
        .ser_valid(ser_valid), .ser_data(ser_data), .ser_ready(ser_ready), .got(got),
        .got_byte(got_byte));

    // ************************************************************
    // compare, write and closing tasks
    // ************************************************************
    task automatic cmp_byte(input logic [8:0] e, input logic [7:0] a);
        checks++;
        if (!e[8] && a !== e[7:0]) begin
            num_errors++;
            $display("[ERR] %0t exp %h got %h", $time, e[7:0], a);
        end
    endtask
    task automatic cmp_val(input logic [15:0] e, input logic [15:0] a);
        checks++;
        if (a !== e) begin
            num_errors++;
            $display("[ERR] %0t exp %h got %h", $time, e, a);
        end
    endtask
    task automatic wr(input logic [3:0] b, input logic [1:0] s, input logic [2:0] i,
                      input logic [15:0] d);
        @(negedge sys_clk);
        host_wr = 1'b1; host_buf = b; host_sel = s; host_byte = i; host_wdata = d;
    endtask
    task automatic wr_end;
        @(negedge sys_clk);
        host_wr = 1'b0;
    endtask
    task automatic prep(input logic [3:0] b, input logic [3:0] len);
        logic [15:0] hi, lo, d;
        hi = 16'($urandom);
        lo = 16'($urandom);
        // any buffer is deactivated before its contents change
        wr(b, `CTX_SEL_CTRL, 3'h0, {8'h00, `CTX_CODE_TX_OFF, len});
        wr(b, `CTX_SEL_IDHI, 3'h0, hi);
        wr(b, `CTX_SEL_IDLO, 3'h0, lo);
        fr[b].delete();
        fr[b].push_back({1'b0, hi[15:8]});
        fr[b].push_back({1'b0, hi[7:0]});
        fr[b].push_back({1'b0, lo[15:8]});
        fr[b].push_back({1'b0, lo[7:0]});
        // length byte never reports more than eight
        fr[b].push_back({5'h00, (len > `CTX_MAX_LEN) ? `CTX_MAX_LEN : len});
        for (int i = 0; i < `CTX_MAX_BYTES; i++) begin
            d = 16'($urandom);
            wr(b, `CTX_SEL_DATA, i[2:0], d);
            if (i < len) fr[b].push_back({1'b0, d[7:0]});
        end
    endtask
    task automatic act(input logic [3:0] b, input logic [3:0] len);
        wr(b, `CTX_SEL_CTRL, 3'h0, {8'h00, `CTX_CODE_TX_ON, len});
    endtask
    task automatic note(input logic [3:0] b);
        for (int k = 0; k < fr[b].size(); k++) exp_q.push_back(fr[b][k]);
        buf_q.push_back(b);
    endtask
    task automatic drain;
        for (int n = 0; n < 2000 && (exp_q.size() || buf_q.size() || tx_busy); n++)
            @(negedge sys_clk);
        cmp_val(16'h0, 16'(exp_q.size() + buf_q.size() + tx_busy));
    endtask
    task automatic stop_test;
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // watcher takes the oldest note whenever a result shows
    always @(posedge sys_clk) begin
        if (tx_busy) busy_seen++;
        if (got) cmp_byte(exp_q.size() ? exp_q.pop_front() : 9'h000, got_byte);
        if (tx_done) cmp_val({12'h0, buf_q.size() ? buf_q.pop_front() : 4'hf}, 16'(tx_buf));
    end

    // runaway guard sized far above the planned traffic
    initial begin
        #400000;
        num_errors++;
        stop_test;
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        host_wr = 1'b0; host_buf = 4'h0; host_sel = 2'h0; host_byte = 3'h0;
        host_wdata = 16'h0000; freeze_req = 1'b1; bus_idle = 1'b0; interframe = 1'b0;
        stall_en = 1'b0; rst_b = 1'b0;
        void'($urandom(37));
        repeat (16) @(negedge sys_clk);
        rst_b = 1'b1;
        bus_idle = 1'b1;
        repeat (20) @(negedge sys_clk);
        cmp_val(16'h0, 16'(synced));
        freeze_req = 1'b0;
        repeat (8) @(negedge sys_clk);
        cmp_val(16'h0, 16'(synced));
        repeat (8) @(negedge sys_clk);
        cmp_val(16'h1, 16'(synced));
        // boundary lengths on random buffers, far side stalling
        stall_en = 1'b1;
        foreach (lens[j]) begin
            mark = $urandom % 16;
            prep(mark[3:0], lens[j][3:0]);
            note(mark[3:0]);
            act(mark[3:0], lens[j][3:0]);
            wr_end;
            drain;
        end
        // two buffers wait on a busy bus, then the inter-frame space opens
        bus_idle = 1'b0;
        prep(4'h9, 4'hc);
        prep(4'h2, 4'h5);
        note(4'h2);
        note(4'h9);
        act(4'h9, 4'hc);
        act(4'h2, 4'h5);
        wr_end;
        mark = busy_seen;
        repeat (10) @(negedge sys_clk);
        cmp_val(16'h0, 16'(busy_seen - mark));
        interframe = 1'b1;
        drain;
        // inactive buffer edited on a free bus starts nothing
        bus_idle = 1'b1;
        mark = busy_seen;
        prep(4'h7, 4'h4);
        wr_end;
        repeat (40) @(negedge sys_clk);
        cmp_val(16'h0, 16'(busy_seen - mark));
        stop_test;
    end
endmodule // ctx_tx_core_bench
`default_nettype wire
